// File: hdl/adc_diag_map.svh
// constants for the adc diagnostic checker
// Behaviour
// - open driver output read back as flag
// - short detection only on half-bridges
// - floating analog input raises readable flag
// - sensor supply short/open raises readable flag
`ifndef ADC_DIAG_MAP_SVH
`define ADC_DIAG_MAP_SVH
`define SEL_RATIO_A 5'h19
`define SEL_RATIO_B 5'h1A
`define SEL_HALF_REF 5'h1B
`define SEL_REF 5'h1C
`define SEL_REG_5V 5'h1D
`define SEL_REG_2V5 5'h1E
`define SEL_CUR_MUX 5'h1F
`define EXP_RATIO_A 10'h2AA
`define EXP_RATIO_B 10'h155
`define EXP_MID 10'h200
`define EXP_CUR 10'h066
`define TOL_15 10'h00F
`define TOL_30 10'h01E
`define TOL_50 10'h032
`define TOL_10 10'h00A
`define NUM_CHECKS 7
`define FLAG_WIDTH 4
`define FLAG_OPEN_LOAD 0
`define FLAG_SHORT 1
`define FLAG_AIN_FLOAT 2
`define FLAG_SENS_SUPPLY 3
`endif

// File: hdl/adc_diag_pkg.sv
// types for the adc diagnostic checker
`default_nettype none
package adc_diag_pkg;
  typedef struct packed {
    logic [4:0] sel;
    logic start;
  } adc_req_t;
  typedef struct packed {
    logic [9:0] result;
    logic done;
  } adc_rsp_t;
  typedef struct packed {
    logic openLoad;
    logic shortRail;
    logic ainFloat;
    logic sensSupply;
  } sbd_flags_t;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    ISSUE = 3'b001,
    WAIT_CONV = 3'b010,
    FLAGS = 3'b011,
    WAIT_FLAGS = 3'b100,
    FINISH = 3'b101
  } diag_state_t;
endpackage : adc_diag_pkg
`default_nettype wire

// File: hdl/adc_diagnostic_checker.sv
// self-test sequencer for adc channels and die status flags
`include "adc_diag_map.svh"
`default_nettype none
module adc_diagnostic_checker
  import adc_diag_pkg::*;
#(
  parameter int NUM_CHECKS = `NUM_CHECKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic clearFail,
  input wire logic sampleRateOk,
  input wire logic sensorSupplyReady,
  output logic posSensorSupplySwitchEn,
  output logic negSensorSupplySwitchEn,
  output adc_req_t adcReq,
  input wire adc_rsp_t adcRsp,
  output logic flagReadReq,
  input wire logic flagReadDone,
  input wire sbd_flags_t flagData,
  output logic [NUM_CHECKS-1:0] checkPass,
  output logic [NUM_CHECKS-1:0] checkFail,
  output sbd_flags_t flagStatus,
  output logic busy,
  output logic done,
  output logic failEvent,
  output logic failLatched
);
  localparam logic [4:0] SEL_TAB [7] = '{`SEL_RATIO_A, `SEL_RATIO_B, `SEL_HALF_REF,
    `SEL_REF, `SEL_REG_5V, `SEL_REG_2V5, `SEL_CUR_MUX};
  localparam logic [9:0] EXP_TAB [7] = '{`EXP_RATIO_A, `EXP_RATIO_B, `EXP_MID,
    `EXP_MID, `EXP_MID, `EXP_MID, `EXP_CUR};
  localparam logic [9:0] TOL_TAB [7] = '{`TOL_15, `TOL_15, `TOL_15,
    `TOL_30, `TOL_50, `TOL_50, `TOL_10};

  diag_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  sbd_flags_t flags_reg, flags_next;
  logic [1:0] supplySync_reg, supplySync_next;
  logic supplyEn_reg, supplyEn_next;
  logic done_reg, done_next;
  logic failL_reg, failL_next, evt_reg, evt_next;
  logic [9:0] lo, hi;
  logic inWindow, checkBad, flagBad, supplyOk;
  logic accept, convTaken, flagTaken, lastCheck;

  // supply presence may come from an external source, so it passes two flops first
  always_comb begin
    supplySync_next = {supplySync_reg[0], sensorSupplyReady};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supplySync_reg <= '0;
    end else begin
      supplySync_reg <= supplySync_next;
    end
  end

  assign supplyOk = supplySync_reg[1];

  // window bounds per check, inclusive; the low bound is clamped at zero, the high bound is not clamped
  always_comb begin
    lo = (EXP_TAB[idx_reg] > TOL_TAB[idx_reg]) ? EXP_TAB[idx_reg] - TOL_TAB[idx_reg] : 10'h000;
    hi = EXP_TAB[idx_reg] + TOL_TAB[idx_reg];
    inWindow = (adcRsp.result >= lo) && (adcRsp.result <= hi);
  end

  assign accept = (state_reg == IDLE) && start && sampleRateOk;
  assign convTaken = (state_reg == WAIT_CONV) && adcRsp.done;
  assign flagTaken = (state_reg == WAIT_FLAGS) && flagReadDone;
  assign lastCheck = (idx_reg == 3'(NUM_CHECKS - 1));
  assign checkBad = convTaken && !inWindow;
  // open load, half-bridge short, floating input and supply fault all fail
  assign flagBad = flagTaken && (|flagData);

  // sequencer: seven conversions, then one status read
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    flags_next = flags_reg;
    case (state_reg)
      IDLE: begin
        // out-of-range sample rate would give false failures, so start is held off
        if (accept) begin
          idx_next = 3'h0;
          flags_next = '0;
          state_next = ISSUE;
        end
      end
      ISSUE: begin
        if (supplyOk) begin
          state_next = WAIT_CONV;
        end
      end
      WAIT_CONV: begin
        // a done seen in any other state is ignored
        if (convTaken) begin
          if (lastCheck) begin
            state_next = FLAGS;
          end else begin
            idx_next = idx_reg + 3'h1;
            state_next = ISSUE;
          end
        end
      end
      FLAGS: begin
        state_next = WAIT_FLAGS;
      end
      WAIT_FLAGS: begin
        if (flagTaken) begin
          flags_next = flagData;
          state_next = FINISH;
        end
      end
      FINISH: begin
        state_next = IDLE;
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      idx_reg <= 3'h0;
      flags_reg <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      flags_reg <= flags_next;
    end
  end

  // supply stays on for the whole run, not only the ratiometric pair
  always_comb begin
    supplyEn_next = supplyEn_reg;
    done_next = done_reg;
    if (accept) begin
      supplyEn_next = 1'b1;
      done_next = 1'b0;
    end else if (state_reg == FINISH) begin
      supplyEn_next = 1'b0;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supplyEn_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      supplyEn_reg <= supplyEn_next;
      done_reg <= done_next;
    end
  end

  // a new failure beats a clear in the same cycle
  always_comb begin
    evt_next = checkBad || flagBad;
    failL_next = failL_reg;
    if (clearFail) begin
      failL_next = 1'b0;
    end
    if (checkBad || flagBad) begin
      failL_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      failL_reg <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      failL_reg <= failL_next;
      evt_reg <= evt_next;
    end
  end

  // one status pair per check; an accepted start clears every pair, then only the check being run may move its pair
  for (genvar g = 0; g < NUM_CHECKS; g++) begin : gen_check
    logic passBit_reg, passBit_next, failBit_reg, failBit_next;
    always_comb begin
      passBit_next = passBit_reg;
      failBit_next = failBit_reg;
      if (accept) begin
        passBit_next = 1'b0;
        failBit_next = 1'b0;
      end else if (convTaken && (idx_reg == 3'(g))) begin
        passBit_next = inWindow;
        failBit_next = !inWindow;
      end
    end

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        passBit_reg <= 1'b0;
        failBit_reg <= 1'b0;
      end else begin
        passBit_reg <= passBit_next;
        failBit_reg <= failBit_next;
      end
    end

    assign checkPass[g] = passBit_reg;
    assign checkFail[g] = failBit_reg;
  end

  // selector follows the index, so it shows the first check out of reset
  assign adcReq.sel = SEL_TAB[idx_reg];
  assign adcReq.start = (state_reg == ISSUE) && supplyOk;
  assign flagReadReq = (state_reg == FLAGS);
  assign posSensorSupplySwitchEn = supplyEn_reg;
  assign negSensorSupplySwitchEn = supplyEn_reg;
  assign flagStatus = flags_reg;
  assign busy = (state_reg != IDLE);
  assign done = done_reg;
  assign failEvent = evt_reg;
  assign failLatched = failL_reg;
endmodule : adc_diagnostic_checker
`default_nettype wire

// File: bench/adc_diag_asserts.sv
// port checker for the adc diagnostic checker
`default_nettype none
module adc_diag_asserts
  import adc_diag_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic sampleRateOk,
  input wire logic clearFail,
  input wire logic posSensorSupplySwitchEn,
  input wire logic negSensorSupplySwitchEn,
  input wire adc_req_t adcReq,
  input wire adc_rsp_t adcRsp,
  input wire logic flagReadDone,
  input wire sbd_flags_t flagData,
  input wire sbd_flags_t flagStatus,
  input wire logic busy,
  input wire logic done,
  input wire logic failEvent,
  input wire logic failLatched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking
    @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence seqEnd;
    flagReadDone ##2 $rose(done);
  endsequence
  flag_cap_a: assert property (seqEnd |-> flagStatus == $past(flagData, 2))
    else $error("flags");
  flag_fail_a: assert property (seqEnd |-> $past(failEvent) == (|flagStatus))
    else $error("flag fail");
  fail_sticky_a: assert property (failLatched && !clearFail |=> failLatched)
    else $error("sticky");
  event_latch_a: assert property (failEvent |-> failLatched)
    else $error("latch");
  high_result_a: assert property (adcRsp.done && busy && adcReq.sel == 5'h19
    && adcRsp.result > 10'h2B9 |=> failEvent)
    else $error("window");
  supply_on_a: assert property (adcReq.start |-> posSensorSupplySwitchEn
    && negSensorSupplySwitchEn)
    else $error("supply");
  rate_gate_a: assert property (!busy && start && !sampleRateOk |=> !busy)
    else $error("rate gate");
endmodule : adc_diag_asserts
`default_nettype wire

// File: bench/adc_diag_partner.sv
// adc result path and status die model
`default_nettype none
module adc_diag_partner
  import adc_diag_pkg::*;
(
  input wire logic clock,
  input wire adc_req_t adcReq,
  input wire logic flagReadReq,
  input wire logic [69:0] res,
  input wire logic [3:0] lat,
  input wire sbd_flags_t flags,
  output adc_rsp_t adcRsp = '0,
  output logic flagReadDone = 1'b0,
  output sbd_flags_t flagData = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  int i = 0;
  always @(posedge clock) begin
    // idle lines show junk, never the last value
    adcRsp <= {~res[i*10+:10], 1'b0};
    flagReadDone <= flagReadReq;
    flagData <= flagReadReq ? flags : ~flags;
    // the result follows the selector, so a selector below 5'h19 reads back unknown and any other selector reads that entry's value
    if (adcReq.start) begin
      n <= lat;
      i <= int'(adcReq.sel) - 25;
    end else if (n > 0) begin
      n <= n - 1;
    end
    if (n == 1) begin
      adcRsp <= {res[i*10+:10], 1'b1};
    end
  end
endmodule : adc_diag_partner
`default_nettype wire

// File: bench/adc_diagnostic_checker_tb.sv
// testbench for the adc diagnostic checker
`default_nettype none
module adc_diagnostic_checker_tb
  import adc_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, start = 1'b0, clearFail = 1'b0;
  logic sampleRateOk = 1'b1;
  logic [69:0] res = '0;
  logic [3:0] lat = 4'h1;
  sbd_flags_t flags = '0, flagData, flagStatus;
  logic [6:0] checkPass, checkFail;
  logic posSensorSupplySwitchEn, negSensorSupplySwitchEn, flagReadReq, flagReadDone;
  logic busy, done, failEvent, failLatched;
  adc_req_t adcReq;
  adc_rsp_t adcRsp;
  // internal switches stand for the supply here, so ready follows the enable
  wire logic sensorSupplyReady = posSensorSupplySwitchEn;
  int nMismatch = 0;
  int checksDone = 0;
  adc_diagnostic_checker uut (.clock, .rst_n, .start, .clearFail, .sampleRateOk,
    .sensorSupplyReady, .posSensorSupplySwitchEn, .negSensorSupplySwitchEn, .adcReq,
    .adcRsp, .flagReadReq, .flagReadDone, .flagData, .checkPass, .checkFail, .flagStatus,
    .busy, .done, .failEvent, .failLatched);
  adc_diag_partner model (.clock, .adcReq, .flagReadReq, .res, .lat, .flags, .adcRsp,
    .flagReadDone, .flagData);
  initial begin
    forever #2 clock = ~clock;
  end
  task endOfTest;
    if (nMismatch == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : endOfTest
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task run(input logic [69:0] r, input logic [3:0] l, input sbd_flags_t f, input logic pass);
    @(posedge clock);
    res <= r;
    lat <= l;
    flags <= f;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(negedge clock);
    for (int k = 0; k < 500 && done !== 1'b1; k++) @(negedge clock);
    // a run that never finishes counts as a mismatch here
    chk("done", 16'h1, 16'(done));
    chk("busy", 16'h0, 16'(busy));
    chk("pass", pass ? 16'h7F : 16'h0, 16'(checkPass));
    chk("fail", pass ? 16'h0 : 16'h7F, 16'(checkFail));
    chk("flags", 16'(f), 16'(flagStatus));
    chk("latched", 16'(!pass || f != '0), 16'(failLatched));
    // clearing tells a stale latch from a fresh one
    @(posedge clock);
    clearFail <= 1'b1;
    @(posedge clock);
    clearFail <= 1'b0;
    @(negedge clock);
    chk("cleared", 16'h0, 16'(failLatched));
  endtask : run
  task rateGate;
    @(posedge clock);
    sampleRateOk <= 1'b0;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    chk("gated", 16'h0, 16'(busy));
    @(posedge clock);
    sampleRateOk <= 1'b1;
  endtask : rateGate
  task windowEdges;
    run({10'h05C, 10'h232, 10'h1CE, 10'h21E, 10'h1F1, 10'h164, 10'h29B}, 4'h1, '0, 1'b1);
    run({10'h071, 10'h1CD, 10'h233, 10'h1E1, 10'h210, 10'h145, 10'h2BA}, 4'h9, '0, 1'b0);
  endtask : windowEdges
  task flagEach;
    for (int k = 0; k < 4; k++) begin
      run({10'h066, {4{10'h200}}, 10'h155, 10'h2AA}, 4'h2, sbd_flags_t'(4'h1 << k), 1'b1);
    end
  endtask : flagEach
  initial begin
    #100000;
    nMismatch++;
    endOfTest;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rateGate;
    windowEdges;
    flagEach;
    endOfTest;
  end
endmodule : adc_diagnostic_checker_tb
bind adc_diagnostic_checker adc_diag_asserts checker_i (.clock, .rst_n, .start, .clearFail,
  .sampleRateOk, .posSensorSupplySwitchEn, .negSensorSupplySwitchEn, .adcReq, .adcRsp,
  .flagReadDone, .flagData, .flagStatus, .busy, .done, .failEvent, .failLatched);
`default_nettype wire
